// ===== rtl/rmc_control_word.sv
// rmc_control_word: receive mode command control word, host port plus device side updates.
// assumes a single-cycle host word port and a protocol engine that pulses msg_done_i once per message.
//
// How it works
// - access interrupt bit with global enable raises an interrupt request on each valid command
// - broadcast interrupt bit with global enable raises request on valid broadcast receive
// - broadcast disabled makes address 31 commands invalid, broadcast interrupt inert
// - host sets force busy bit; commands to this mode code answer with Busy
// - global busy from status word bits register also applies Busy
// - under Busy, data words for mode codes 16-31 not stored, pointer unchanged
// - accessed flag set when message processing completes
// - accessed flag cleared by master reset, software reset or host read
// - buffer pointer is read-only to host, meaningful only in ping-pong mode
// - pointer 0 selects data pointer A, 1 selects data pointer B
// - in ping-pong mode without toggle-hold, pointer inverts after every message not answered with Busy
// - toggle-hold config keeps pointer after illegal or error-ended messages
// - pointer cleared by master reset and software reset, so buffer A first
// - word applies to receive commands with subaddress 0 or 31
// - buffer mode bit set selects ping-pong, clear selects indexed single buffer
module rmc_control_word (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire logic master_reset_n_i,
    input wire logic software_reset_cmd_i,
    // host word port
    input wire logic host_wr_i,
    input wire logic host_rd_i,
    input wire logic [rmc_pkg::RMC_WORD_W-1:0] host_wdata_i,
    input wire logic exec_running_i,
    output logic [rmc_pkg::RMC_WORD_W-1:0] host_rdata_o,
    // configuration
    input wire logic access_irq_enable_i,
    input wire logic bcast_irq_enable_i,
    input wire logic broadcast_disable_cfg_i,
    input wire logic pointer_toggle_hold_cfg_i,
    input wire logic global_busy_i,
    // completed command from the protocol engine
    input wire logic cmd_start_i,
    input wire logic msg_done_i,
    input wire logic msg_error_i,
    input wire logic [4:0] rt_addr_i,
    input wire logic tr_bit_i,
    input wire logic [4:0] subaddr_i,
    input wire logic [4:0] mode_code_i,
    // answers to the protocol engine
    output logic busy_status_o,
    output logic data_store_en_o,
    output logic use_pointer_b_o,
    output logic access_irq_o,
    output logic bcast_irq_o,
    output logic log_entry_o
);
    import rmc_pkg::*;

    logic applies;
    logic is_bcast;
    logic valid;
    logic has_data;
    logic [RMC_WORD_W-1:0] word_r;
    logic [RMC_WORD_W-1:0] word_nxt;

    rmc_cmd_decode u_decode (
        .rt_addr_i(rt_addr_i),
        .tr_bit_i(tr_bit_i),
        .subaddr_i(subaddr_i),
        .mode_code_i(mode_code_i),
        .broadcast_disable_cfg_i(broadcast_disable_cfg_i),
        .applies_o(applies),
        .is_bcast_o(is_bcast),
        .valid_o(valid),
        .has_data_o(has_data)
    );

    // ************************************************************
    // master reset pin synchroniser
    // ************************************************************
    logic mr_meta_r;
    logic mr_meta_nxt;
    logic mr_sync_n_r;
    logic mr_sync_n_nxt;

    always_comb begin
        mr_meta_nxt = master_reset_n_i;
        mr_sync_n_nxt = mr_meta_r;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mr_meta_r <= 1'b0;
            mr_sync_n_r <= 1'b0;
        end else if (clk_en_i) begin
            mr_meta_r <= mr_meta_nxt;
            mr_sync_n_r <= mr_sync_n_nxt;
        end
    end

    // ************************************************************
    // message sequencer
    // ************************************************************
    rmc_state_type state_r;
    rmc_state_type state_nxt;
    logic busy_r;
    logic busy_nxt;
    logic store_r;
    logic store_nxt;
    logic bcast_r;
    logic bcast_nxt;
    logic valid_r;
    logic valid_nxt;

    always_comb begin
        state_nxt = state_r;
        busy_nxt = busy_r;
        store_nxt = store_r;
        bcast_nxt = bcast_r;
        valid_nxt = valid_r;
        unique case (state_r)
            RMC_IDLE: begin
                if (cmd_start_i && applies) begin
                    state_nxt = RMC_EVAL;
                    // per mode code busy or global busy
                    busy_nxt = word_r[RMC_BIT_FORCE_BUSY] || global_busy_i;
                    // busy blocks storage of mode data words
                    store_nxt = valid && has_data && !(word_r[RMC_BIT_FORCE_BUSY] || global_busy_i);
                    bcast_nxt = is_bcast;
                    valid_nxt = valid;
                end
            end
            RMC_EVAL: begin
                if (msg_done_i) begin
                    state_nxt = RMC_WRITE_BACK;
                end
            end
            RMC_WRITE_BACK: begin
                state_nxt = RMC_IDLE;
                busy_nxt = 1'b0;
                store_nxt = 1'b0;
            end
        endcase
        if (!mr_sync_n_r || software_reset_cmd_i) begin
            state_nxt = RMC_IDLE;
            busy_nxt = 1'b0;
            store_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_r <= RMC_IDLE;
            busy_r <= 1'b0;
            store_r <= 1'b0;
            bcast_r <= 1'b0;
            valid_r <= 1'b0;
        end else if (clk_en_i) begin
            state_r <= state_nxt;
            busy_r <= busy_nxt;
            store_r <= store_nxt;
            bcast_r <= bcast_nxt;
            valid_r <= valid_nxt;
        end
    end

    // ************************************************************
    // control word and event outputs
    // ************************************************************
    logic [RMC_WORD_W-1:0] rdata_r;
    logic [RMC_WORD_W-1:0] rdata_nxt;
    logic acc_irq_r;
    logic acc_irq_nxt;
    logic bc_irq_r;
    logic bc_irq_nxt;
    logic log_r;
    logic log_nxt;
    logic completing;
    logic good_msg;
    logic hold_ptr;
    logic [RMC_WORD_W-1:0] wmask;

    always_comb begin
        word_nxt = word_r;
        rdata_nxt = rdata_r;
        acc_irq_nxt = 1'b0;
        bc_irq_nxt = 1'b0;
        log_nxt = 1'b0;
        completing = (state_r == RMC_EVAL) && msg_done_i;
        good_msg = valid_r && !msg_error_i && !busy_r;
        // pointer held under busy always; after illegal commands only with toggle hold
        hold_ptr = busy_r || (pointer_toggle_hold_cfg_i && !valid_r);
        wmask = RMC_HOST_WR_MASK | (exec_running_i ? 16'h0000 : RMC_HOST_WR_MASK_STOPPED);
        // host writes reach only host bits; pointer and accessed stay device owned
        if (host_wr_i) begin
            word_nxt = (word_r & ~wmask) | (host_wdata_i & wmask);
        end
        if (host_rd_i) begin
            rdata_nxt = word_r;
            // read clears the accessed flag
            word_nxt[RMC_BIT_ACCESSED] = 1'b0;
        end
        if (completing) begin
            // set wins over a read in the same cycle
            word_nxt[RMC_BIT_ACCESSED] = 1'b1;
            if (valid_r && bcast_r) begin
                word_nxt[RMC_BIT_BCAST_RCVD] = 1'b1;
            end
            // ping-pong only; indexed mode leaves the pointer alone
            if (word_r[RMC_BIT_MODE_SEL] && !hold_ptr && (good_msg || !pointer_toggle_hold_cfg_i)) begin
                word_nxt[RMC_BIT_BUF_PTR] = ~word_r[RMC_BIT_BUF_PTR];
            end
            if (valid_r && word_r[RMC_BIT_ACCESS_IRQ] && access_irq_enable_i) begin
                acc_irq_nxt = 1'b1;
            end
            if (valid_r && bcast_r && word_r[RMC_BIT_BCAST_IRQ] && bcast_irq_enable_i) begin
                bc_irq_nxt = 1'b1;
            end
            log_nxt = acc_irq_nxt || bc_irq_nxt;
        end
        if (software_reset_cmd_i) begin
            word_nxt = word_nxt & ~RMC_SOFTWARE_RESET_CMD_CLEAR_MASK;
            acc_irq_nxt = 1'b0;
            bc_irq_nxt = 1'b0;
            log_nxt = 1'b0;
        end
        if (!mr_sync_n_r) begin
            word_nxt = RMC_WORD_RESET;
            rdata_nxt = RMC_WORD_RESET;
            acc_irq_nxt = 1'b0;
            bc_irq_nxt = 1'b0;
            log_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            word_r <= RMC_WORD_RESET;
            rdata_r <= RMC_WORD_RESET;
            acc_irq_r <= 1'b0;
            bc_irq_r <= 1'b0;
            log_r <= 1'b0;
        end else if (clk_en_i) begin
            word_r <= word_nxt;
            rdata_r <= rdata_nxt;
            acc_irq_r <= acc_irq_nxt;
            bc_irq_r <= bc_irq_nxt;
            log_r <= log_nxt;
        end
    end

    // ************************************************************
    // registered answers
    // ************************************************************
    logic ptr_b_r;
    logic ptr_b_nxt;

    always_comb begin
        // a selects 0, b selects 1; forced to a in indexed mode
        ptr_b_nxt = word_nxt[RMC_BIT_BUF_PTR] && word_nxt[RMC_BIT_MODE_SEL];
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ptr_b_r <= 1'b0;
        end else if (clk_en_i) begin
            ptr_b_r <= ptr_b_nxt;
        end
    end

    assign host_rdata_o = rdata_r;
    assign busy_status_o = busy_r;
    assign data_store_en_o = store_r;
    assign use_pointer_b_o = ptr_b_r;
    assign access_irq_o = acc_irq_r;
    assign bcast_irq_o = bc_irq_r;
    assign log_entry_o = log_r;

endmodule

// ===== rtl/rmc_pkg.sv
// rmc_pkg: bit layout, reset values and sequencer states of the receive mode command control word.
// assumes one 16-bit word, reached through the documented descriptor word port of the block.
package rmc_pkg;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int unsigned RMC_WORD_W = 16;
    localparam int unsigned RMC_BIT_ACCESS_IRQ = 14;
    localparam int unsigned RMC_BIT_BCAST_IRQ = 13;
    localparam int unsigned RMC_BIT_FORCE_BUSY = 12;
    localparam int unsigned RMC_BIT_ACCESSED = 11;
    localparam int unsigned RMC_BIT_BUF_PTR = 10;
    localparam int unsigned RMC_BIT_BCAST_RCVD = 9;
    localparam int unsigned RMC_BIT_MODE_SEL = 2;

    // ************************************************************
    // decode values and reset values
    // ************************************************************
    localparam logic [4:0] RMC_BCAST_ADDR = 5'h1f;
    localparam logic [4:0] RMC_SUBADDR_MODE0 = 5'h00;
    localparam logic [4:0] RMC_SUBADDR_MODE31 = 5'h1f;
    localparam logic [4:0] RMC_DATA_MC_FIRST = 5'h10;
    localparam logic [15:0] RMC_WORD_RESET = 16'h0000;
    // host may always write bits 15..12 and 3; bit 2 only while execution is stopped
    localparam logic [15:0] RMC_HOST_WR_MASK = 16'hf008;
    localparam logic [15:0] RMC_HOST_WR_MASK_STOPPED = 16'h0004;
    // software reset clears accessed, buffer pointer and broadcast flags only
    localparam logic [15:0] RMC_SOFTWARE_RESET_CMD_CLEAR_MASK = 16'h0e00;

    typedef enum logic [1:0] {
        RMC_IDLE,
        RMC_EVAL,
        RMC_WRITE_BACK
    } rmc_state_type;

endpackage

// ===== rtl/rmc_cmd_decode.sv
// rmc_cmd_decode: classifies a completed 1553 command for the receive mode control word.
// assumes inputs are registered on clk_sys_i by the protocol engine; purely combinational.
module rmc_cmd_decode (
    input wire logic [4:0] rt_addr_i,
    input wire logic tr_bit_i,
    input wire logic [4:0] subaddr_i,
    input wire logic [4:0] mode_code_i,
    input wire logic broadcast_disable_cfg_i,
    output logic applies_o,
    output logic is_bcast_o,
    output logic valid_o,
    output logic has_data_o
);
    import rmc_pkg::*;

    always_comb begin
        // receive with subaddress 0 or 31 selects this word
        applies_o = !tr_bit_i && (subaddr_i == RMC_SUBADDR_MODE0 || subaddr_i == RMC_SUBADDR_MODE31);
        is_bcast_o = (rt_addr_i == RMC_BCAST_ADDR);
        // address 31 is not a valid command while broadcast is disabled
        valid_o = applies_o && !(is_bcast_o && broadcast_disable_cfg_i);
        has_data_o = (mode_code_i >= RMC_DATA_MC_FIRST);
    end
endmodule

// ===== verif/rmc_control_word_chk.sv
// rmc_control_word_chk: port-level timing checks for the receive mode command control word.
// assumes clk_en_i held high and one message in flight at a time.
module rmc_control_word_chk (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic master_reset_n_i,
    input wire logic software_reset_cmd_i,
    input wire logic host_wr_i,
    input wire logic host_rd_i,
    input wire logic access_irq_enable_i,
    input wire logic bcast_irq_enable_i,
    input wire logic broadcast_disable_cfg_i,
    input wire logic global_busy_i,
    input wire logic cmd_start_i,
    input wire logic msg_done_i,
    input wire logic [4:0] rt_addr_i,
    input wire logic tr_bit_i,
    input wire logic [4:0] subaddr_i,
    input wire logic [4:0] mode_code_i,
    input wire logic [15:0] host_rdata_o,
    input wire logic busy_status_o,
    input wire logic data_store_en_o,
    input wire logic use_pointer_b_o,
    input wire logic access_irq_o,
    input wire logic bcast_irq_o,
    input wire logic log_entry_o
);
    // ************************************************************
    // message tracker and properties
    // ************************************************************
    logic in_msg_r;
    logic in_msg_nxt;
    // only a command seen while nothing is in flight is known to be taken
    always_comb begin
        in_msg_nxt = (in_msg_r | cmd_start_i) & ~msg_done_i;
    end
    always_ff @(posedge clk_sys_i) begin
        in_msg_r <= rst_i ? 1'b0 : in_msg_nxt;
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i || !master_reset_n_i);
    acc_irq_cause_a: assert property (access_irq_o |-> $past(msg_done_i) && $past(access_irq_enable_i))
        else $error("access interrupt without cause");
    acc_irq_pulse_a: assert property (access_irq_o |=> !access_irq_o)
        else $error("access interrupt longer than one cycle");
    bc_irq_cause_a: assert property (bcast_irq_o |-> $past(msg_done_i) && $past(bcast_irq_enable_i)
        && !$past(broadcast_disable_cfg_i))
        else $error("broadcast interrupt without cause");
    irq_logged_a: assert property (access_irq_o || bcast_irq_o |-> log_entry_o)
        else $error("interrupt not logged");
    glob_busy_a: assert property (cmd_start_i && !in_msg_r && !$past(msg_done_i) && global_busy_i
        && !tr_bit_i && subaddr_i == 5'h00 && rt_addr_i != 5'h1f |=> busy_status_o)
        else $error("global busy not answered");
    store_gate_a: assert property ($rose(data_store_en_o) |-> $past(mode_code_i) >= 5'h10 && !$past(global_busy_i))
        else $error("data stored under busy or low mode code");
    busy_span_a: assert property (msg_done_i && busy_status_o |=> busy_status_o ##1 !busy_status_o)
        else $error("busy span wrong");
    read_clear_a: assert property (host_rd_i && !msg_done_i ##1 !msg_done_i ##1 host_rd_i |=> !host_rdata_o[11])
        else $error("accessed flag survived a read");
    ptr_source_a: assert property ($changed(use_pointer_b_o) |->
        $past(msg_done_i) || $past(software_reset_cmd_i) || $past(host_wr_i))
        else $error("buffer pointer changed without cause");
endmodule
bind rmc_control_word rmc_control_word_chk u_chk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .master_reset_n_i(master_reset_n_i),
    .software_reset_cmd_i(software_reset_cmd_i), .host_wr_i(host_wr_i), .host_rd_i(host_rd_i),
    .access_irq_enable_i(access_irq_enable_i), .bcast_irq_enable_i(bcast_irq_enable_i),
    .broadcast_disable_cfg_i(broadcast_disable_cfg_i), .global_busy_i(global_busy_i),
    .cmd_start_i(cmd_start_i), .msg_done_i(msg_done_i), .rt_addr_i(rt_addr_i), .tr_bit_i(tr_bit_i),
    .subaddr_i(subaddr_i), .mode_code_i(mode_code_i), .host_rdata_o(host_rdata_o),
    .busy_status_o(busy_status_o), .data_store_en_o(data_store_en_o), .use_pointer_b_o(use_pointer_b_o),
    .access_irq_o(access_irq_o), .bcast_irq_o(bcast_irq_o), .log_entry_o(log_entry_o)
);

// ===== verif/rmc_host_model.sv
// rmc_host_model: host side of the control word port, one word per access.
// assumes the bench calls its tasks hierarchically, one access at a time.
module rmc_host_model (
    input wire logic clk_sys_i,
    input wire logic [15:0] host_rdata_i,
    output logic host_wr_o,
    output logic host_rd_o,
    output logic [15:0] host_wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // word accesses
    // ************************************************************
    initial begin
        host_wr_o = 1'b0;
        host_rd_o = 1'b0;
        host_wdata_o = 16'h0000;
    end
    // host sets force busy and buffer mode bits through plain writes
    task automatic write_word(input logic [15:0] d);
        @(posedge clk_sys_i) #2;
        host_wr_o = 1'b1;
        host_wdata_o = d;
        @(posedge clk_sys_i) #2;
        host_wr_o = 1'b0;
        // released data is scrambled so a stale value cannot pass
        host_wdata_o = ~d;
    endtask
    task automatic read_word(output logic [15:0] d);
        @(posedge clk_sys_i) #2;
        host_rd_o = 1'b1;
        @(posedge clk_sys_i) #2;
        host_rd_o = 1'b0;
        d = host_rdata_i;
    endtask
endmodule

// ===== verif/rmc_control_word_tb_top.sv
// rmc_control_word_tb_top: directed checks of the control word through host and message tasks.
// assumes the checker is bound in; clk_en_i and the broadcast interrupt enable stay high, the access interrupt enable drops for one message.
module rmc_control_word_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import rmc_pkg::*;
    // ************************************************************
    // stimulus and checks
    // ************************************************************
    logic clk_sys_i = 0, rst_i = 1, mrst_n = 1, software_reset_cmd = 0, run = 0, bdis = 0, hold = 0, gbusy = 0;
    logic cs = 0, done = 0, err = 0, tr = 0, wr, rd, bsy_o, sto_o, ptrb, airq, birq, bsy, sto;
    logic aen = 1, ben = 1, lg;
    logic [4:0] rta = 0, sa = 0, mc = 0;
    logic [15:0] wd, rdat, rv;
    int err_count = 0, cmp_count = 0, na = 0, nb = 0, nl = 0;
    always #25 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        if (airq === 1'b1) na++;
        if (birq === 1'b1) nb++;
        if (lg === 1'b1) nl++;
    end
    rmc_host_model host (.clk_sys_i(clk_sys_i), .host_rdata_i(rdat), .host_wr_o(wr), .host_rd_o(rd),
        .host_wdata_o(wd));
    rmc_control_word dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_en_i(1'b1), .master_reset_n_i(mrst_n),
        .software_reset_cmd_i(software_reset_cmd), .host_wr_i(wr), .host_rd_i(rd), .host_wdata_i(wd), .exec_running_i(run),
        .host_rdata_o(rdat), .access_irq_enable_i(aen), .bcast_irq_enable_i(ben),
        .broadcast_disable_cfg_i(bdis), .pointer_toggle_hold_cfg_i(hold), .global_busy_i(gbusy),
        .cmd_start_i(cs), .msg_done_i(done), .msg_error_i(err), .rt_addr_i(rta), .tr_bit_i(tr),
        .subaddr_i(sa), .mode_code_i(mc), .busy_status_o(bsy_o), .data_store_en_o(sto_o),
        .use_pointer_b_o(ptrb), .access_irq_o(airq), .bcast_irq_o(birq), .log_entry_o(lg));
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [15:0] exp);
        host.read_word(rv);
        chk(rv, exp);
    endtask
    // one command, then completion a cycle later, then idle gap
    task automatic msg(input logic [4:0] a, input logic t, input logic [4:0] s, input logic [4:0] m,
        input logic e);
        @(posedge clk_sys_i) #2;
        cs = 1; rta = a; tr = t; sa = s; mc = m;
        @(posedge clk_sys_i) #2;
        cs = 0; bsy = bsy_o; sto = sto_o; done = 1; err = e;
        @(posedge clk_sys_i) #2;
        done = 0;
        repeat (3) @(posedge clk_sys_i);
    endtask
    initial begin
        repeat (4000) @(posedge clk_sys_i);
        err_count++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge clk_sys_i);
        #2 rst_i = 0;
        repeat (3) @(posedge clk_sys_i);
        rdchk(16'h0000);
        host.write_word(16'hffff);
        rdchk(16'hf00c);
        host.write_word(16'h6004);
        msg(5'h01, 0, 5'h00, 5'h11, 0);
        chk(16'(sto), 16'h0001);
        rdchk(16'h6c04);
        chk(16'(ptrb), 16'h0001);
        rdchk(16'h6404);
        chk(16'(na), 16'h0001);
        msg(5'h01, 1, 5'h00, 5'h11, 0);
        rdchk(16'h6404);
        chk(16'(na), 16'h0001);
        run = 1;
        host.write_word(16'h7000);
        msg(5'h01, 0, 5'h1f, 5'h12, 0);
        chk({bsy, sto}, 16'h0002);
        rdchk(16'h7c04);
        host.write_word(16'h6000);
        gbusy = 1;
        msg(5'h01, 0, 5'h00, 5'h13, 0);
        gbusy = 0;
        chk({bsy, sto}, 16'h0002);
        rdchk(16'h6c04);
        hold = 1;
        msg(5'h01, 0, 5'h00, 5'h14, 1);
        hold = 0;
        rdchk(16'h6c04);
        msg(5'h1f, 0, 5'h00, 5'h15, 0);
        rdchk(16'h6a04);
        bdis = 1;
        msg(5'h1f, 0, 5'h00, 5'h15, 0);
        chk(16'(nb), 16'h0001);
        aen = 0;
        msg(5'h01, 0, 5'h00, 5'h16, 0);
        aen = 1;
        chk(16'(na), 16'h0005);
        chk(16'(nl), 16'h0005);
        @(posedge clk_sys_i) #2 software_reset_cmd = 1;
        @(posedge clk_sys_i) #2 software_reset_cmd = 0;
        rdchk(16'h6004);
        chk(16'(ptrb), 16'h0000);
        mrst_n = 0;
        repeat (4) @(posedge clk_sys_i);
        #2 mrst_n = 1;
        repeat (3) @(posedge clk_sys_i);
        rdchk(16'h0000);
        report_and_stop();
    end
endmodule
